/* File: core/ccdsc_conv.sv */
`timescale 1ns/1ns
module ccdsc_conv #(
  parameter int COARSE_CYC = ccdsc_pkg::COARSE_STEP_CYC,
  parameter int FINE_CYC = ccdsc_pkg::FINE_STEP_CYC
) (
  input wire logic pclk, // Block clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // One-cycle start of a conversion
  input wire logic [7:0] level, // Level at the converter input
  output logic [7:0] result, // Last complete result
  output logic done, // One-cycle pulse, result valid
  output logic busy, // Conversion in progress
  output logic autozero, // Comparators acquiring and zeroing
  output logic coarse_active, // Upper-nibble flash step
  output logic fine_active // Residue flash step
);

  typedef enum logic [2:0] {
    CV_ACQ = 3'b001,
    CV_COARSE = 3'b010,
    CV_FINE = 3'b100
  } ccdsc_conv_state_type;

  typedef struct packed {
    ccdsc_conv_state_type state;
    logic [7:0] cnt;
    logic [7:0] samp;
    logic [7:0] residue;
    logic [3:0] upper;
    logic [7:0] result;
    logic done;
  } ccdsc_conv_st_type;

  localparam ccdsc_conv_st_type ST_RESET = '{state: CV_ACQ, default: '0};
  localparam int CONV_CYC = COARSE_CYC + FINE_CYC + 1;

  ccdsc_conv_st_type q;
  ccdsc_conv_st_type d;

  // Fifteen comparators against a ladder of the given step
  function automatic logic [3:0] flash15(input logic [7:0] v,
                                         input logic [7:0] step);
    logic [3:0] n;
    logic [8:0] thr;
    n = 4'h0;
    thr = 9'h000;
    for (int k = 1; k < 16; k++) begin
      thr = thr + {1'b0, step};
      if ({1'b0, v} >= thr) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // ***************************************************************
  // Two-step sequencer
  // ***************************************************************
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.state)
      CV_ACQ: begin
        if (start) begin
          d.samp = level;
          d.cnt = 8'(COARSE_CYC - 1);
          d.state = CV_COARSE;
        end
      end
      CV_COARSE: begin
        if (q.cnt == 8'h00) begin
          d.upper = flash15(q.samp, 8'h10);
          d.residue = q.samp - {d.upper, 4'h0};
          d.cnt = 8'(FINE_CYC - 1);
          d.state = CV_FINE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      CV_FINE: begin
        if (q.cnt == 8'h00) begin
          d.result = {q.upper, flash15(q.residue, 8'h01)};
          d.done = 1'b1;
          d.state = CV_ACQ;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        d.state = CV_ACQ;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign result = q.result;
  assign done = q.done;
  assign busy = (q.state != CV_ACQ);
  assign autozero = (q.state == CV_ACQ);
  assign coarse_active = (q.state == CV_COARSE);
  assign fine_active = (q.state == CV_FINE);

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_coarse_then_fine: assert property (@(posedge pclk)
    disable iff (!presetn)
      (q.state == CV_COARSE && q.cnt == 8'h00) |=> fine_active)
    else $error("coarse step not followed by fine step");

  a_result_exact: assert property (@(posedge pclk)
    disable iff (!presetn) done |-> (result == q.samp))
    else $error("two-step result differs from sampled level");

  a_conv_length: assert property (@(posedge pclk)
    disable iff (!presetn)
      (autozero && start) |-> ##CONV_CYC (done && autozero))
    else $error("conversion did not end on time in acquisition");

endmodule // ccdsc_conv

/* File: core/ccdsc_core.sv */
// Overview of operation
// - Gain register holds six bits, 64 settings from -2 down by -0.125.
// - Clamp switch follows the clamp strobe level two clock cycles behind it, closed while it is high.
// - Sample strobe high stores offset; low selects inverting amplify.
// - Result built in two flash steps: upper nibble, then residue nibble.
// - Two timed steps, then comparators return to acquisition and zeroing.
// - At most one of sensor, aux 1 or aux 2 feeds the converter; none during the break gap.
// - Channel change opens the old path before closing the new one.
// - Every serial transfer is an eight-bit word.
// - Mode 0 shifts control bits in; mode 1 shifts results out.
// - Serial bits move on rising edges of the shift clock.
// - In mode 0 the data output driver is off.
// - Sample strobe fall loads the output shifter with a stored result.
// - Top bit shows after strobe fall; each clock rise gives next bit.
// - After the last bit, further clocks give undefined data.
// - Storage and output stages give two pixel cycles of latency.
// - Word starts with address bit 0, address bit 1, then six payload.
// - Load rising after eight bits moves payload to addressed register.
// - Address 00 selector, 01 gain, bit 0 set does nothing.
// - Gain payload is plain binary, top bit first.
// - Reset gives sensor input and gain code zero.
`timescale 1ns/1ns
module ccdsc_core (
  input wire logic pclk, // Block clock, 20 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic serial_shift_clock, // Serial clock pin
  input wire logic mode, // Direction pin, 1 shifts results out
  input wire logic load, // Register load pin
  input wire logic serial_data_in, // Data pin, input side
  output logic serial_data_out, // Data pin, output side
  output logic serial_data_oe, // Data pin driver enable
  input wire logic video_sample_strobe, // Pixel strobe pin
  input wire logic black_clamp_strobe, // Clamp strobe pin
  input wire logic [7:0] converter_level, // Level at converter input
  output logic clamp_switch_closed, // Clamp switch state
  output logic offset_null_switch, // Unity-gain offset storing
  output logic offset_null_switch_pos, // Companion offset switch
  output logic amplify_switch, // Inverting amplify path
  output logic [5:0] gain_code, // Gain stage code
  output logic [2:0] input_path_closed, // Sensor, aux 1, aux 2
  output logic comparators_autozero, // Converter acquiring
  output logic conv_coarse, // Converter upper step
  output logic conv_fine // Converter residue step
);

  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] mode_s;
    logic [1:0] load_s;
    logic [1:0] din_s;
    logic [1:0] vs_s;
    logic [1:0] clp_s;
    logic sck_p;
    logic load_p;
    logic vs_p;
    logic [7:0] in_sh;
    logic [3:0] in_cnt;
    logic [7:0] out_sh;
    logic [7:0] store;
    logic [2:0] sel;
    logic [5:0] gain;
    logic [31:0] prdata;
    logic perr;
  } ccdsc_core_st_type;

  localparam ccdsc_core_st_type ST_RESET = '{
    sel: ccdsc_pkg::SELECT_RESET,
    gain: ccdsc_pkg::GAIN_RESET,
    default: '0};
  localparam logic [3:0] WORD_CNT = 4'(ccdsc_pkg::WORD_BITS);

  ccdsc_core_st_type q;
  ccdsc_core_st_type d;

  logic sck_rise;
  logic load_rise;
  logic vs_fall;
  logic mode_out;
  logic apb_setup;
  logic apb_write;
  logic [7:0] conv_result;
  logic conv_done;
  logic conv_busy;

  function automatic logic path_legal(input logic [2:0] p);
    return (p == ccdsc_pkg::PATH_SENSOR) || (p == ccdsc_pkg::PATH_AUX1) ||
           (p == ccdsc_pkg::PATH_AUX2);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == ccdsc_pkg::ADDR_SELECT) || (a == ccdsc_pkg::ADDR_GAIN) ||
           (a == ccdsc_pkg::ADDR_STATUS) || (a == ccdsc_pkg::ADDR_RESULT);
  endfunction

  // Pin edges seen only on the second synchroniser stage
  assign sck_rise = q.sck_s[1] & ~q.sck_p;
  assign load_rise = q.load_s[1] & ~q.load_p;
  assign vs_fall = q.vs_p & ~q.vs_s[1];
  assign mode_out = q.mode_s[1];
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;

  // ***************************************************************
  // Converter and input selector
  // ***************************************************************
  ccdsc_conv u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .start(vs_fall),
    .level(converter_level),
    .result(conv_result),
    .done(conv_done),
    .busy(conv_busy),
    .autozero(comparators_autozero),
    .coarse_active(conv_coarse),
    .fine_active(conv_fine)
  );

  ccdsc_mux u_mux (
    .pclk(pclk),
    .presetn(presetn),
    .req_path(q.sel),
    .path_closed(input_path_closed)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    d = q;
    d.sck_s = {q.sck_s[0], serial_shift_clock};
    d.mode_s = {q.mode_s[0], mode};
    d.load_s = {q.load_s[0], load};
    d.din_s = {q.din_s[0], serial_data_in};
    d.vs_s = {q.vs_s[0], video_sample_strobe};
    d.clp_s = {q.clp_s[0], black_clamp_strobe};
    d.sck_p = q.sck_s[1];
    d.load_p = q.load_s[1];
    d.vs_p = q.vs_s[1];

    // Result pipeline: conversion, storage, output shifter
    if (vs_fall) begin
      d.store = conv_result;
      d.out_sh = q.store;
    end else if (mode_out && sck_rise) begin
      d.out_sh = {q.out_sh[6:0], 1'b0};
    end

    // Register reads are captured in the setup phase
    if (apb_setup) begin
      d.perr = ~addr_mapped(paddr);
      case (paddr)
        ccdsc_pkg::ADDR_SELECT: begin
          d.prdata = 32'(q.sel);
        end
        ccdsc_pkg::ADDR_GAIN: begin
          d.prdata = 32'(q.gain);
        end
        ccdsc_pkg::ADDR_STATUS: begin
          d.prdata = 32'h0000_0000;
          d.prdata[ccdsc_pkg::STAT_MODE_POS] = mode_out;
          d.prdata[ccdsc_pkg::STAT_CNT_LSB +: 4] = q.in_cnt;
          d.prdata[ccdsc_pkg::STAT_BUSY_POS] = conv_busy;
          d.prdata[ccdsc_pkg::STAT_PATH_LSB +: 3] = input_path_closed;
        end
        ccdsc_pkg::ADDR_RESULT: begin
          d.prdata = 32'(q.store);
        end
        default: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end

    // Software writes; an illegal path code is ignored
    if (apb_write) begin
      if (paddr == ccdsc_pkg::ADDR_SELECT && path_legal(pwdata[2:0])) begin
        d.sel = pwdata[2:0];
      end
      if (paddr == ccdsc_pkg::ADDR_GAIN) begin
        d.gain = pwdata[5:0];
      end
    end

    // Serial control words; a serial load overrides a same-cycle write
    if (!mode_out) begin
      if (sck_rise) begin
        d.in_sh = {q.in_sh[6:0], q.din_s[1]};
        if (q.in_cnt != WORD_CNT) begin
          d.in_cnt = q.in_cnt + 4'h1;
        end
      end
      if (load_rise) begin
        if (q.in_cnt == WORD_CNT && !q.in_sh[ccdsc_pkg::ADDR0_POS]) begin
          if (q.in_sh[ccdsc_pkg::ADDR1_POS]) begin
            d.gain = q.in_sh[5:0];
          end else begin
            case (q.in_sh[ccdsc_pkg::SELCODE_LSB +: 3])
              ccdsc_pkg::SELCODE_SENSOR: begin
                d.sel = ccdsc_pkg::PATH_SENSOR;
              end
              ccdsc_pkg::SELCODE_AUX1: begin
                d.sel = ccdsc_pkg::PATH_AUX1;
              end
              ccdsc_pkg::SELCODE_AUX2: begin
                d.sel = ccdsc_pkg::PATH_AUX2;
              end
              default: begin
                d.sel = q.sel;
              end
            endcase
          end
        end
        d.in_cnt = 4'h0;
      end
    end else begin
      d.in_cnt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign prdata = q.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & q.perr;
  assign serial_data_out = q.out_sh[7];
  assign serial_data_oe = mode_out;
  assign clamp_switch_closed = q.clp_s[1];
  assign offset_null_switch = q.vs_s[1];
  assign offset_null_switch_pos = q.vs_s[1];
  assign amplify_switch = ~q.vs_s[1];
  assign gain_code = q.gain;

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_driver_off: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(q.mode_s[0]) |=> !serial_data_oe)
    else $error("data driver on while shifting in");

  a_switch_phase: assert property (@(posedge pclk)
    disable iff (!presetn) (offset_null_switch != amplify_switch) &&
      (offset_null_switch_pos == offset_null_switch) &&
      (offset_null_switch == $past(q.vs_s[0])))
    else $error("gain stage switches overlap or lag");

  a_amp_phase: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(q.vs_s[0]) |=>
      (amplify_switch && !offset_null_switch))
    else $error("amplify path not taken after strobe fall");

  a_clamp_level: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(q.clp_s[0]) |=> clamp_switch_closed)
    else $error("clamp switch did not close");

  a_clamp_open: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(q.clp_s[0]) |=> !clamp_switch_closed)
    else $error("clamp switch did not open");

  a_result_load: assert property (@(posedge pclk)
    disable iff (!presetn) vs_fall |=> (q.out_sh == $past(q.store)) &&
      (q.store == $past(conv_result)))
    else $error("strobe fall did not advance result pipeline");

  a_shift_next: assert property (@(posedge pclk)
    disable iff (!presetn) (mode_out && sck_rise && !vs_fall) |=>
      (serial_data_out == $past(q.out_sh[6])))
    else $error("shift clock did not present next bit");

  a_bit_hold: assert property (@(posedge pclk)
    disable iff (!presetn) (!vs_fall && !(mode_out && sck_rise)) |=>
      $stable(serial_data_out))
    else $error("output bit changed without clock or strobe");

  a_in_shift: assert property (@(posedge pclk)
    disable iff (!presetn) (!mode_out && sck_rise) |=>
      (q.in_sh[0] == $past(q.din_s[1])))
    else $error("data pin not shifted in on clock rise");

  a_cnt_limit: assert property (@(posedge pclk)
    disable iff (!presetn) q.in_cnt <= WORD_CNT)
    else $error("serial bit count above word length");

  a_mode_clear: assert property (@(posedge pclk)
    disable iff (!presetn) mode_out |=> (q.in_cnt == 4'h0))
    else $error("bit count kept while shifting out");

  a_gain_word: assert property (@(posedge pclk)
    disable iff (!presetn) (!mode_out && load_rise &&
      q.in_cnt == WORD_CNT && q.in_sh[7:6] == 2'b01) |=>
      (gain_code == $past(q.in_sh[5:0])))
    else $error("gain word not transferred on load");

  a_sel_sensor: assert property (@(posedge pclk)
    disable iff (!presetn) (!mode_out && load_rise &&
      q.in_cnt == WORD_CNT && q.in_sh[7:6] == 2'b00 &&
      q.in_sh[5:3] == ccdsc_pkg::SELCODE_SENSOR) |=>
      (q.sel == ccdsc_pkg::PATH_SENSOR))
    else $error("sensor select word not transferred");

  a_sel_aux1: assert property (@(posedge pclk)
    disable iff (!presetn) (!mode_out && load_rise &&
      q.in_cnt == WORD_CNT && q.in_sh[7:6] == 2'b00 &&
      q.in_sh[5:3] == ccdsc_pkg::SELCODE_AUX1) |=>
      (q.sel == ccdsc_pkg::PATH_AUX1))
    else $error("aux 1 select word not transferred");

  a_sel_aux2: assert property (@(posedge pclk)
    disable iff (!presetn) (!mode_out && load_rise &&
      q.in_cnt == WORD_CNT && q.in_sh[7:6] == 2'b00 &&
      q.in_sh[5:3] == ccdsc_pkg::SELCODE_AUX2) |=>
      (q.sel == ccdsc_pkg::PATH_AUX2))
    else $error("aux 2 select word not transferred");

  a_apb_gain: assert property (@(posedge pclk)
    disable iff (!presetn) (apb_write && paddr == ccdsc_pkg::ADDR_GAIN &&
      !load_rise) |=> (gain_code == $past(pwdata[5:0])))
    else $error("gain write from bus not taken");

  a_noop_word: assert property (@(posedge pclk)
    disable iff (!presetn) (load_rise && !apb_write &&
      q.in_sh[ccdsc_pkg::ADDR0_POS]) |=>
      ($stable(q.gain) && $stable(q.sel)))
    else $error("no-op word changed a register");

  a_short_word: assert property (@(posedge pclk)
    disable iff (!presetn) (load_rise && q.in_cnt != WORD_CNT &&
      !apb_write) |=> ($stable(q.gain) && $stable(q.sel)))
    else $error("short word changed a register");

endmodule // ccdsc_core

/* File: core/ccdsc_mux.sv */
`timescale 1ns/1ns
module ccdsc_mux #(
  parameter int BBM_CYC = ccdsc_pkg::BBM_GAP_CYC
) (
  input wire logic pclk, // Block clock
  input wire logic presetn, // Async reset, active low
  input wire logic [2:0] req_path, // Requested path, one-hot
  output logic [2:0] path_closed // Closed switches, one-hot or none
);

  typedef struct packed {
    logic [2:0] closed;
    logic [3:0] cnt;
  } ccdsc_mux_st_type;

  localparam ccdsc_mux_st_type ST_RESET = '{
    closed: ccdsc_pkg::SELECT_RESET, cnt: 4'h0};
  localparam int BBM_MAX = BBM_CYC + 2;

  ccdsc_mux_st_type q;
  ccdsc_mux_st_type d;

  // Open every switch first, wait the gap, then close the new one
  always_comb begin
    d = q;
    if (q.closed != 3'h0) begin
      if (q.closed != req_path) begin
        d.closed = 3'h0;
        d.cnt = 4'(BBM_CYC);
      end
    end else if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
    end else begin
      d.closed = req_path;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign path_closed = q.closed;

  a_one_path: assert property (@(posedge pclk)
    disable iff (!presetn) $onehot0(q.closed))
    else $error("more than one input path closed");

  a_break_first: assert property (@(posedge pclk)
    disable iff (!presetn)
      ($past(q.closed) != 3'h0 && q.closed != $past(q.closed))
      |-> (q.closed == 3'h0))
    else $error("new path closed before old path opened");

  a_reconnect: assert property (@(posedge pclk)
    disable iff (!presetn)
      (q.closed == 3'h0) |-> ##[1:BBM_MAX] (q.closed != 3'h0))
    else $error("no path closed after break gap");

endmodule // ccdsc_mux

/* File: core/ccdsc_pkg.sv */
package ccdsc_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int PCLK_PERIOD_NS = 50;
  localparam int COARSE_STEP_NS = 250;
  localparam int FINE_STEP_NS = 250;
  localparam int BBM_GAP_NS = 50;

  // Least times round up, never below one cycle
  function automatic int cyc_ceil(input int t_ns);
    int c;
    c = (t_ns + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int COARSE_STEP_CYC = cyc_ceil(COARSE_STEP_NS);
  localparam int FINE_STEP_CYC = cyc_ceil(FINE_STEP_NS);
  localparam int BBM_GAP_CYC = cyc_ceil(BBM_GAP_NS);

  // ***************************************************************
  // Serial word layout
  // ***************************************************************
  localparam int WORD_BITS = 8;
  localparam int ADDR0_POS = 7;
  localparam int ADDR1_POS = 6;
  localparam int PAYLOAD_W = 6;
  localparam int SELCODE_LSB = 3;
  localparam logic [2:0] SELCODE_SENSOR = 3'h0;
  localparam logic [2:0] SELCODE_AUX1 = 3'h2;
  localparam logic [2:0] SELCODE_AUX2 = 3'h4;

  // ***************************************************************
  // Input paths, one-hot
  // ***************************************************************
  localparam logic [2:0] PATH_SENSOR = 3'h1;
  localparam logic [2:0] PATH_AUX1 = 3'h2;
  localparam logic [2:0] PATH_AUX2 = 3'h4;

  // ***************************************************************
  // Register map and reset values
  // ***************************************************************
  localparam int PADDR_W = 12;
  localparam logic [11:0] ADDR_SELECT = 12'h000;
  localparam logic [11:0] ADDR_GAIN = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00c;
  localparam logic [2:0] SELECT_RESET = 3'h1;
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam int STAT_MODE_POS = 0;
  localparam int STAT_CNT_LSB = 1;
  localparam int STAT_BUSY_POS = 5;
  localparam int STAT_PATH_LSB = 8;

endpackage

/* File: test/ccdsc_ctl_model.sv */
`timescale 1ns/1ns
// ****
// Scanner controller model
// ****
module ccdsc_ctl_model (
  input wire logic pclk, // Bench clock
  input wire logic serial_data_out, // Device data driver
  input wire logic serial_data_oe, // Device driver enable
  output logic serial_data_in, // Resolved data line
  output logic serial_shift_clock = 1'b0, // Shift clock, idle low
  output logic mode = 1'b0, // Direction
  output logic load = 1'b0, // Register load
  output logic video_sample_strobe = 1'b0, // Pixel strobe
  output logic black_clamp_strobe = 1'b0 // Clamp strobe
);
  logic drv_en = 1'b0;
  logic drv_d = 1'b0;
  logic flip = 1'b0;

  // Released line toggles so a stale bit never reads back
  always @(posedge pclk) flip <= ~flip;
  assign serial_data_in = serial_data_oe ? serial_data_out :
    (drv_en ? drv_d : flip);

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Data changes with the falling clock, held across the rise
  task automatic send_word(input logic [7:0] w, input int nbits);
    drv_en <= 1'b1;
    for (int i = 7; i > 7 - nbits; i--) begin
      drv_d <= w[i];
      serial_shift_clock <= 1'b0;
      tick(4);
      serial_shift_clock <= 1'b1;
      tick(4);
    end
    serial_shift_clock <= 1'b0;
    tick(4);
    load <= 1'b1;
    tick(4);
    load <= 1'b0;
    tick(4);
  endtask

  task automatic set_mode(input logic m);
    if (m) drv_en <= 1'b0;
    tick(4);
    mode <= m;
    tick(4);
  endtask

  task automatic strobe_rise;
    video_sample_strobe <= 1'b1;
    tick(10);
  endtask

  task automatic clamp(input logic v);
    black_clamp_strobe <= v;
    tick(6);
  endtask

  // Only eight bits taken; later clocks carry nothing usable
  task automatic read_word(output logic [7:0] got);
    video_sample_strobe <= 1'b0;
    tick(8);
    got[7] = serial_data_in;
    for (int i = 6; i >= 0; i--) begin
      serial_shift_clock <= 1'b1;
      tick(4);
      serial_shift_clock <= 1'b0;
      tick(4);
      got[i] = serial_data_in;
    end
  endtask
endmodule // ccdsc_ctl_model

/* File: test/tb_ccd_digitizer_serial_control.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) begin \
      bad_count++; \
      $display("Error %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb_ccd_digitizer_serial_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0] converter_level;
  logic [31:0] prdata;
  logic pready, pslverr, serial_data_out, serial_data_oe;
  logic clamp_switch_closed, offset_null_switch, offset_null_switch_pos;
  logic amplify_switch, comparators_autozero, conv_coarse, conv_fine;
  logic [5:0] gain_code;
  logic [2:0] input_path_closed;
  logic serial_shift_clock, mode, load, serial_data_in;
  logic video_sample_strobe, black_clamp_strobe;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] rd, ex;
  logic er;
  logic [7:0] got, lvl;
  logic [7:0] lv [$];
  logic [5:0] g;
  logic [2:0] sc [3] = '{ccdsc_pkg::SELCODE_AUX1, ccdsc_pkg::SELCODE_AUX2,
    ccdsc_pkg::SELCODE_SENSOR};
  logic [2:0] pe [3] = '{ccdsc_pkg::PATH_AUX1, ccdsc_pkg::PATH_AUX2,
    ccdsc_pkg::PATH_SENSOR};

  always #25 pclk = ~pclk;

  ccdsc_core i_dut (.*);
  ccdsc_ctl_model i_ctl (.*);

  always @(posedge pclk) begin
    if (presetn) `CHK("one_path", 1'b1, $countones(input_path_closed) <= 1)
  end

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run is about 1500 cycles; limit of 8000 cycles leaves wide margin
  initial begin
    #400_000;
    bad_count++;
    tally_and_finish();
  end

  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(87490));
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'($urandom);
    converter_level <= 8'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("gain_rst", 6'h00, gain_code)
    `CHK("path_rst", ccdsc_pkg::PATH_SENSOR, input_path_closed)
    `CHK("oe_mode0", 1'b0, serial_data_oe)
    apb(1'b0, ccdsc_pkg::ADDR_GAIN, 32'h0);
    `CHK("gain_reg_rst", 32'h0000_0000, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    $display("Test reset done");
    for (int i = 0; i < 6; i++) begin
      g = (i == 0) ? 6'h3f : (i == 1) ? 6'h01 : 6'($urandom);
      i_ctl.send_word({2'b01, g}, 8);
      `CHK("gain", g, gain_code)
      apb(1'b0, ccdsc_pkg::ADDR_GAIN, 32'h0);
      `CHK("gain_reg", {26'h0, g}, rd)
    end
    i_ctl.send_word({2'b01, ~g}, 7);
    `CHK("short_word", g, gain_code)
    i_ctl.send_word({1'b1, 7'($urandom)}, 8);
    `CHK("noop_word", g, gain_code)
    g = 6'($urandom);
    apb(1'b1, ccdsc_pkg::ADDR_GAIN, {26'($urandom), g});
    `CHK("apb_gain", g, gain_code)
    $display("Test gain done");
    for (int i = 0; i < 3; i++) begin
      i_ctl.send_word({2'b00, sc[i], 3'($urandom)}, 8);
      i_ctl.tick(4);
      `CHK("path", pe[i], input_path_closed)
    end
    apb(1'b1, ccdsc_pkg::ADDR_SELECT, 32'h0000_0004);
    i_ctl.tick(6);
    `CHK("apb_path", ccdsc_pkg::PATH_AUX2, input_path_closed)
    $display("Test selector done");
    i_ctl.clamp(1'b1);
    `CHK("clamp_on", 1'b1, clamp_switch_closed)
    i_ctl.clamp(1'b0);
    `CHK("clamp_off", 1'b0, clamp_switch_closed)
    i_ctl.set_mode(1'b1);
    `CHK("oe_mode1", 1'b1, serial_data_oe)
    for (int k = 0; k < 8; k++) begin
      lvl = (k == 2) ? 8'hff : (k == 3) ? 8'h00 : 8'($urandom);
      converter_level <= lvl;
      lv.push_back(lvl);
      i_ctl.strobe_rise();
      `CHK("offset_null", 1'b1, offset_null_switch)
      `CHK("amp_off", 1'b0, amplify_switch)
      `CHK("offset_pos", 1'b1, offset_null_switch_pos)
      i_ctl.read_word(got);
      `CHK("amp_on", 1'b1, amplify_switch)
      `CHK("autozero", 1'b1, comparators_autozero)
      `CHK("conv_idle", 2'b00, {conv_coarse, conv_fine})
      if (k >= 2) `CHK("result", lv[k-2], got)
    end
    apb(1'b0, ccdsc_pkg::ADDR_RESULT, 32'h0000_0000);
    `CHK("result_reg", 32'(lv[6]), rd)
    ex = 32'(ccdsc_pkg::PATH_AUX2) << ccdsc_pkg::STAT_PATH_LSB;
    ex[ccdsc_pkg::STAT_MODE_POS] = 1'b1;
    apb(1'b0, ccdsc_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("status", ex, rd)
    i_ctl.set_mode(1'b0);
    `CHK("oe_back", 1'b0, serial_data_oe)
    $display("Test readout done");
    tally_and_finish();
  end
endmodule // tb_ccd_digitizer_serial_control
